//--- core/dual_autoreload_timer_clkout.sv
// Top of the dual 16-bit auto-reload timer with clock outputs and Wishbone slave
module dual_autoreload_timer_clkout (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Wishbone classic slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic            wb_ack_o,
    // External count pins
    input  wire logic       timerAPin,
    input  wire logic       timerBPin,
    // Clock output pins and their enables
    output logic            timerAClkOut,
    output logic            timerAClkOutEn,
    output logic            timerBClkOut,
    output logic            timerBClkOutEn,
    // Interrupt
    output logic            irq
);
    logic [7:0]  control_ff;
    logic [7:0]  irqEnable_ff;
    logic [7:0]  irqStatus_ff;
    logic [31:0] rdData_ff;
    logic        ack_ff;
    logic        irq_ff;
    logic        aClkEn_ff;
    logic        bClkEn_ff;
    logic [15:0] countA;
    logic [15:0] countB;
    logic        ovfA;
    logic        ovfB;
    logic        clkA;
    logic        clkB;
    logic [15:0] chCount [2];
    logic [1:0]  chOvf;
    logic [1:0]  chClk;

    // Channel count; index 0 is timer A, index 1 is timer B
    localparam int NUM_CHAN = 2;

    // Bus decode; one-cycle answer, ack drops the cycle after it is given
    wire logic req   = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire logic wrEn  = req & wb_we_i & wb_sel_i[0];
    wire logic selCtl = (wb_adr_i == timer34_pkg::OFS_CONTROL_MODE);
    wire logic selIe  = (wb_adr_i == timer34_pkg::OFS_IRQ_ENABLE);
    wire logic selSt  = (wb_adr_i == timer34_pkg::OFS_IRQ_STATUS);
    wire logic selBH  = (wb_adr_i == timer34_pkg::OFS_B_COUNT_HIGH);
    wire logic selBL  = (wb_adr_i == timer34_pkg::OFS_B_COUNT_LOW);
    wire logic selAH  = (wb_adr_i == timer34_pkg::OFS_A_COUNT_HIGH);
    wire logic selAL  = (wb_adr_i == timer34_pkg::OFS_A_COUNT_LOW);
    wire logic [7:0] wrByte = wb_dat_i[7:0];

    // Unmapped addresses read zero and writes are ignored
    wire logic [7:0] rdByte = selCtl ? control_ff :
                              selIe  ? irqEnable_ff :
                              selSt  ? irqStatus_ff :
                              selBH  ? countB[15:8] :
                              selBL  ? countB[7:0] :
                              selAH  ? countA[15:8] :
                              selAL  ? countA[7:0] : timer34_pkg::RST_BYTE;

    // Sticky events: set wins over a write-one clear in the same cycle
    wire logic [7:0] evt = {ovfB, ovfA, 6'h00} &
                           ((8'h01 << timer34_pkg::BIT_B_IRQ) |
                            (8'h01 << timer34_pkg::BIT_A_IRQ));
    wire logic [7:0] clrMask = (wrEn && selSt) ? wrByte : 8'h00;
    wire logic [7:0] nxt_status = (irqStatus_ff & ~clrMask) | evt;
    wire logic       nxt_irq = |(nxt_status & irqEnable_ff);

    // Control fields gathered per channel so one loop serves both timers
    wire logic [1:0] chRun   = {control_ff[timer34_pkg::BIT_B_RUN],
                                control_ff[timer34_pkg::BIT_A_RUN]};
    wire logic [1:0] chSrc   = {control_ff[timer34_pkg::BIT_B_SOURCE],
                                control_ff[timer34_pkg::BIT_A_SOURCE]};
    wire logic [1:0] chByp   = {control_ff[timer34_pkg::BIT_B_BYPASS],
                                control_ff[timer34_pkg::BIT_A_BYPASS]};
    wire logic [1:0] chClkEn = {control_ff[timer34_pkg::BIT_B_CLOCK_OUT],
                                control_ff[timer34_pkg::BIT_A_CLOCK_OUT]};

    // Count byte strobes; the channel itself decides count or reload
    wire logic [1:0] chWrHi = {wrEn & selBH, wrEn & selAH};
    wire logic [1:0] chWrLo = {wrEn & selBL, wrEn & selAL};
    wire logic [1:0] chPin  = {timerBPin, timerAPin};

    // Control register; a write lands on the edge that takes the request
    always_ff @(posedge clk) begin
        if (rst) begin
            control_ff <= timer34_pkg::RST_BYTE;
        end else if (wrEn && selCtl) begin
            control_ff <= wrByte;
        end
    end

    // Interrupt enable; bits other than the two timer enables are plain storage
    always_ff @(posedge clk) begin
        if (rst) begin
            irqEnable_ff <= timer34_pkg::RST_BYTE;
        end else if (wrEn && selIe) begin
            irqEnable_ff <= wrByte;
        end
    end

    // Sticky status; an overflow in the clearing cycle is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStatus_ff <= timer34_pkg::RST_BYTE;
        end else begin
            irqStatus_ff <= nxt_status;
        end
    end

    // Read data is refreshed every cycle; the master takes it with ack
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_ff <= 32'h0000_0000;
        end else begin
            rdData_ff <= {24'h00_0000, rdByte};
        end
    end

    // One-cycle ack; masking with ack stops a held request being taken twice
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    // Level interrupt, registered so the pin never glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // Pin enable of timer A clock output, one cycle behind its bit
    always_ff @(posedge clk) begin
        if (rst) begin
            aClkEn_ff <= 1'b0;
        end else begin
            aClkEn_ff <= chClkEn[0];
        end
    end

    // Pin enable of timer B clock output, one cycle behind its bit
    always_ff @(posedge clk) begin
        if (rst) begin
            bClkEn_ff <= 1'b0;
        end else begin
            bClkEn_ff <= chClkEn[1];
        end
    end

    // Two identical channels; only their bits and pins differ
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : gen_chan
        timer_channel chan (
            .clk      (clk),
            .rst      (rst),
            .run      (chRun[ch]),
            .sourceSel(chSrc[ch]),
            .bypass   (chByp[ch]),
            .clkOutEn (chClkEn[ch]),
            .wrHigh   (chWrHi[ch]),
            .wrLow    (chWrLo[ch]),
            .wrData   (wrByte),
            .extPin   (chPin[ch]),
            .count    (chCount[ch]),
            .overflow (chOvf[ch]),
            .clkOut   (chClk[ch])
        );
    end

    // Channel results under the names the decode above uses
    assign countA = chCount[0];
    assign countB = chCount[1];
    assign ovfA   = chOvf[0];
    assign ovfB   = chOvf[1];
    assign clkA   = chClk[0];
    assign clkB   = chClk[1];

    assign wb_dat_o       = rdData_ff;
    assign wb_ack_o       = ack_ff;
    assign irq            = irq_ff;
    assign timerAClkOut   = clkA;
    assign timerAClkOutEn = aClkEn_ff;
    assign timerBClkOut   = clkB;
    assign timerBClkOutEn = bClkEn_ff;
endmodule : dual_autoreload_timer_clkout

//--- core/timer34_pkg.sv
// Package with register map, field positions and constants of the dual timer
package timer34_pkg;
    // Register offsets (byte addresses on the Wishbone bus)
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'hAF;
    localparam logic [7:0] OFS_CONTROL_MODE = 8'hD1;
    localparam logic [7:0] OFS_B_COUNT_HIGH = 8'hD2;
    localparam logic [7:0] OFS_B_COUNT_LOW  = 8'hD3;
    localparam logic [7:0] OFS_A_COUNT_HIGH = 8'hD4;
    localparam logic [7:0] OFS_A_COUNT_LOW  = 8'hD5;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'hD8;

    // Control/mode field positions
    localparam int BIT_B_RUN       = 7;
    localparam int BIT_B_SOURCE    = 6;
    localparam int BIT_B_BYPASS    = 5;
    localparam int BIT_B_CLOCK_OUT = 4;
    localparam int BIT_A_RUN       = 3;
    localparam int BIT_A_SOURCE    = 2;
    localparam int BIT_A_BYPASS    = 1;
    localparam int BIT_A_CLOCK_OUT = 0;

    // Interrupt enable and status bit positions
    localparam int BIT_B_IRQ = 7;
    localparam int BIT_A_IRQ = 6;

    // Reset values and the count at which a channel wraps
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] MAX_COUNT = 16'hFFFF;

    // Prescaler: one tick every 12 system clocks
    localparam int         PRESCALE_DIV = 12;
    localparam logic [3:0] PRESCALE_TOP = 4'(PRESCALE_DIV - 1);
    localparam logic [3:0] PRESCALE_ZERO = 4'h0;
endpackage : timer34_pkg

//--- core/timer_channel.sv
// One 16-bit auto-reload timer channel with prescaler, edge counter and clock output
module timer_channel (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        run,
    input  wire logic        sourceSel,
    input  wire logic        bypass,
    input  wire logic        clkOutEn,
    // Count register write port
    input  wire logic        wrHigh,
    input  wire logic        wrLow,
    input  wire logic [7:0]  wrData,
    // External count pin
    input  wire logic        extPin,
    // Results
    output logic      [15:0] count,
    output logic             overflow,
    output logic             clkOut
);
    logic [15:0] count_ff;
    logic [15:0] reload_ff;
    logic [3:0]  pre_ff;
    logic        sync1_ff;
    logic        sync2_ff;
    logic        sync3_ff;
    logic        ovf_ff;
    logic        toggle_ff;
    logic        clkOut_ff;

    wire logic        preHit   = (pre_ff == timer34_pkg::PRESCALE_TOP);
    wire logic        fallEdge = sync3_ff & ~sync2_ff;
    wire logic        intTick  = bypass | preHit;
    wire logic        tick     = run & (sourceSel ? fallEdge : intTick);
    wire logic        wrap     = tick & (count_ff == timer34_pkg::MAX_COUNT);
    wire logic [15:0] nxtReload = {wrHigh ? wrData : reload_ff[15:8],
                                   wrLow  ? wrData : reload_ff[7:0]};
    wire logic [15:0] stoppedWr = {wrHigh ? wrData : count_ff[15:8],
                                   wrLow  ? wrData : count_ff[7:0]};
    wire logic [15:0] nxt_count = wrap ? reload_ff :
                                  (!run && (wrHigh || wrLow)) ? stoppedWr :
                                  tick ? count_ff + 16'h0001 : count_ff;
    wire logic [3:0]  nxt_pre  = (preHit || bypass || !run) ? timer34_pkg::PRESCALE_ZERO
                                                            : pre_ff + 4'h1;

    // Input synchroniser; only the second and third stages are examined
    always_ff @(posedge clk) begin
        sync1_ff <= extPin;
        sync2_ff <= sync1_ff;
        sync3_ff <= sync2_ff;
    end

    // Counter, reload and prescaler state
    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff  <= timer34_pkg::RST_COUNT;
            reload_ff <= timer34_pkg::RST_COUNT;
            pre_ff    <= timer34_pkg::PRESCALE_ZERO;
            ovf_ff    <= 1'b0;
            toggle_ff <= 1'b0;
            clkOut_ff <= 1'b0;
        end else begin
            count_ff  <= nxt_count;
            reload_ff <= nxtReload;
            pre_ff    <= nxt_pre;
            ovf_ff    <= wrap;
            toggle_ff <= toggle_ff ^ wrap;
            clkOut_ff <= clkOutEn & (toggle_ff ^ wrap); // Pin idles low when disabled
        end
    end

    assign count    = count_ff;
    assign overflow = ovf_ff;
    assign clkOut   = clkOut_ff;
endmodule : timer_channel

//--- verification/timer34_assertions.sv
// Checker for the dual timer's bus, clock-out pins and interrupt
module timer34_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // Pins and interrupt
    input wire logic        timerAClkOut,
    input wire logic        timerAClkOutEn,
    input wire logic        timerBClkOut,
    input wire logic        timerBClkOutEn,
    input wire logic        irq
);
    logic [7:0] enSh_ff;
    logic [7:0] ctlSh_ff;
    wire        wrTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    wire        irqOff = !enSh_ff[7] && !enSh_ff[6];
    // Shadows track the registers, which take a write on the taking edge
    always_ff @(posedge clk) begin
        if (rst) begin
            enSh_ff  <= 8'h00;
            ctlSh_ff <= 8'h00;
        end else if (wrTake && wb_adr_i == 8'hAF) begin
            enSh_ff  <= wb_dat_i[7:0];
        end else if (wrTake && wb_adr_i == 8'hD1) begin
            ctlSh_ff <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence reqTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_ONCE: assert property (reqTaken |=> ackPulse)
        else $error("ack not one pulse");
    AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_RST_LOW: assert property (disable iff (1'b0) rst |=> !irq && !timerAClkOut && !timerBClkOut)
        else $error("outputs not cleared by reset");
    AST_EN_B: assert property (timerBClkOutEn == $past(ctlSh_ff[4]))
        else $error("clock-out enable B wrong");
    AST_EN_A: assert property (timerAClkOutEn == $past(ctlSh_ff[0]))
        else $error("clock-out enable A wrong");
    AST_OFF_B: assert property (!timerBClkOutEn && !$past(timerBClkOutEn) |-> !timerBClkOut)
        else $error("clock out B active while off");
    AST_OFF_A: assert property (!timerAClkOutEn && !$past(timerAClkOutEn) |-> !timerAClkOut)
        else $error("clock out A active while off");
    AST_IRQ_MASK: assert property (irqOff && $past(irqOff) |-> !irq)
        else $error("irq while masked");
endmodule : timer34_checker
bind dual_autoreload_timer_clkout timer34_checker chk (.*);

//--- verification/count_pulser.sv
// Model of the external source driving a count pin
module count_pulser (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [3:0] num,
    output logic            pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left;
    logic [2:0] ph;
    logic       busy;
    initial begin
        pin  = 1'b1;
        busy = 1'b0;
    end
    // Each pulse is 4 clocks low then 4 high, long enough for a synchroniser
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            left <= num;
            ph   <= 3'h0;
        end else if (busy) begin
            ph  <= ph + 3'h1;
            pin <= (ph < 3'h4) ? 1'b0 : 1'b1;
            if (ph == 3'h7) begin
                left <= left - 4'h1;
                busy <= (left != 4'h1);
            end
        end
    end
endmodule : count_pulser

//--- verification/dual_autoreload_timer_clkout_tb.sv
// Self-checking bench of the dual auto-reload timer
module dual_autoreload_timer_clkout_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, cyc, stb, we, ack, irq, go, bPin, tAOut, tAEn, tBOut, tBEn;
    logic [3:0]  num;
    logic [7:0]  adr, q;
    logic [31:0] datI, datO;
    int          errorCnt, nCompared;
    // Rows: address, byte written, byte read back (last one unmapped)
    logic [7:0]  rowA [5] = '{8'hAF, 8'hD3, 8'hD2, 8'hD4, 8'h10};
    logic [7:0]  rowD [5] = '{8'hC0, 8'h12, 8'h34, 8'hFF, 8'h5A};
    logic [7:0]  rowE [5] = '{8'hC0, 8'h12, 8'h34, 8'hFF, 8'h00};
    dual_autoreload_timer_clkout uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_ack_o(ack), .timerAPin(1'b1), .timerBPin(bPin), .timerAClkOut(tAOut),
        .timerAClkOutEn(tAEn), .timerBClkOut(tBOut), .timerBClkOutEn(tBEn), .irq(irq));
    count_pulser partner (.clk(clk), .start(go), .num(num), .pin(bPin));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        errorCnt++;
        wrapUp();
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        nCompared++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Classic cycle; ack and data are read as they stood at the rising edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // Cycles between two clock-out toggles of timer A (b=0) or B (b=1)
    task automatic per(input bit b, input int e);
        logic s;
        int n;
        for (int k = 0; k < 2; k++) begin
            s = b ? tBOut : tAOut;
            n = 0;
            while ((b ? tBOut : tAOut) === s && n < 400) begin
                @(negedge clk);
                n++;
            end
        end
        chk(16'(n), 16'(e));
    endtask : per
    task automatic chkIrq(input logic e);
        @(negedge clk);
        chk(irq, e);
        @(posedge clk);
    endtask : chkIrq
    task automatic pulses(input logic [3:0] n);
        num <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (8 * n + 8) @(posedge clk);
    endtask : pulses
    task automatic rstSeq();
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : rstSeq
    task automatic wrapUp();
        $display("compared %0d, errors %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrapUp
    initial begin
        {rst, cyc, stb, we, go, num, adr, datI} = '0;
        errorCnt = 0;
        nCompared = 0;
        rstSeq();
        for (int i = 0; i < 5; i++) begin
            wb(rowA[i], 1'b1, rowD[i]);
            wb(rowA[i], 1'b0, 8'h00);
            chk(q, rowE[i]);
        end
        rstSeq();
        for (int i = 0; i < 4; i++) begin
            wb(8'hD2 + 8'(i), 1'b0, 8'h00);
            chk(q, 8'h00);
        end
        // Timer A undivided from FFF0, enabled interrupt, then masked
        wb(8'hD4, 1'b1, 8'hFF);
        wb(8'hD5, 1'b1, 8'hF0);
        wb(8'hAF, 1'b1, 8'h40);
        wb(8'hD1, 1'b1, 8'h0B);
        per(1'b0, 16);
        chkIrq(1'b1);
        wb(8'hD8, 1'b0, 8'h00);
        chk(q, 8'h40);
        wb(8'hAF, 1'b1, 8'h00);
        chkIrq(1'b0);
        // A write while running only moves the reload
        wb(8'hD5, 1'b1, 8'hF8);
        per(1'b0, 8);
        wb(8'hD1, 1'b1, 8'h02);
        wb(8'hD5, 1'b1, 8'h20);
        repeat (30) @(posedge clk);
        wb(8'hD5, 1'b0, 8'h00);
        chk(q, 8'h20);
        // Timer B divided by 12 from FFFE
        wb(8'hD2, 1'b1, 8'hFF);
        wb(8'hD3, 1'b1, 8'hFE);
        wb(8'hD1, 1'b1, 8'h90);
        per(1'b1, 24);
        // Timer B counting pin edges from FFFD
        wb(8'hD1, 1'b1, 8'h00);
        wb(8'hD3, 1'b1, 8'hFD);
        wb(8'hD8, 1'b1, 8'hFF);
        wb(8'hD1, 1'b1, 8'hC0);
        pulses(4'h2);
        wb(8'hD3, 1'b0, 8'h00);
        chk(q, 8'hFF);
        pulses(4'h1);
        wb(8'hD3, 1'b0, 8'h00);
        chk(q, 8'hFD);
        wb(8'hD8, 1'b0, 8'h00);
        chk(q, 8'h80);
        wrapUp();
    end
endmodule : dual_autoreload_timer_clkout_tb
